// *** design/srpc_stop_reset_ctrl.sv ***
// stop-mode release and reset sequencer top level
//
// Summary of operation
// - unmasked interrupt wakes stop, then service or continue
// - vectored wake waits seventeen or eighteen clocks
// - non-vectored wake waits eleven or twelve clocks
// - masked requests never release stop
// - service decided by priority, enable, in-service flag
// - reset ends stop, then reset vector
// - external main clock skips stabilisation wait
// - reset from pin, watchdog, power-on, low-voltage
// - every reset starts at the reset vector
// - pins high impedance through reset and stabilisation
// - pin release restarts on internal fast oscillator
// - watchdog reset releases itself
// - detector resets release when supply recovers
// - oscillators stopped, external clock ignored in reset
// - stop state kept during reset, pins float
// - low-voltage reset spares the detector logic
// - slow oscillator keeps its prior state in stop
// - serial ports run in stop on allowed clocks
// - two-wire port runs in stop only from its clock pin
// - stop accepted only on main system clock
`timescale 1ns/1ps
module srpc_stop_reset_ctrl (
	// clock and block reset
	input wire logic sys_clk,
	input wire logic rst,
	// reset sources
	input wire logic resetPin_n,
	input wire logic wdtOverflow,
	input wire logic pocLow,
	input wire logic lviLow,
	// cpu side
	input wire logic stopExec,
	input wire logic cpuOnMainClk,
	input wire logic cpuOnExtClk,
	input wire logic xtalEnable,
	input wire logic hsOscStopBit,
	// interrupt controller state, one bit per source for request, mask and priority
	input wire logic [srpc_pkg::NIRQ-1:0] irqReq,
	input wire logic [srpc_pkg::NIRQ-1:0] interruptMaskFlag,
	input wire logic [srpc_pkg::NIRQ-1:0] interruptPriorityFlag,
	input wire logic globalInterruptEnable,
	input wire logic inServicePriorityFlag,
	// serial clock selections
	input wire logic uartClkFromTimer8a,
	input wire logic csiExtClk,
	input wire logic iicExtSerialClockPin,
	// register port
	input wire logic [srpc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [srpc_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [srpc_pkg::DATA_W-1:0] regRdata,
	// cpu control
	output logic cpuClockRun,
	output logic cpuReset,
	output logic fetchResetVector,
	output logic [15:0] resetVectorAddr,
	output logic clkSelHsReset,
	output logic resumeVectored,
	output logic resumeNext,
	output logic stopActive,
	// pins and oscillators
	output logic pinsHighZ,
	output logic crystalOscRun,
	output logic hsOscRun,
	output logic lsOscRun,
	output logic extClkAccept,
	// peripheral run enables and detector logic reset
	output logic uartRun,
	output logic csiRun,
	output logic iicRun,
	output logic lviLogicReset
);
	import srpc_pkg::*;

	srpc_state_t state; // sequencer state
	logic [7:0] ctrlReg; // stabilisation select and slow-oscillator stop
	logic [CAUSE_W-1:0] causeFlags; // sticky reset and refusal causes
	logic [3:0] srcLevel; // registered reset source levels
	logic resetAny; // merged internal reset
	logic resetNoLvi; // merged reset without the voltage detector
	logic stopHeld; // reset arrived while stopped
	logic vecSel; // wake-up will be serviced through a vector
	logic oscStabDone; // stabilisation count has elapsed
	logic stopRejected; // stop refused, pulse
	logic [NIRQ-1:0] unmasked; // requests able to wake
	logic [NIRQ-1:0] serviceable; // requests that will be vectored
	logic wakeAny; // any unmasked request
	logic serveAny; // any vectored request
	logic [TCNT_W-1:0] stabCount; // selected stabilisation length
	logic inResetGrp; // reset or post-reset stabilisation
	logic running; // clocks live outside stop and reset

	srpc_timer_if tif ();

	// wait timer shared by stabilisation and wake-up waits
	srpc_wait_timer uTimer (
		.sysClk(sys_clk),
		.rst(rst),
		.tif(tif.timer)
	);

	// reset source merge
	srpc_reset_merge uMerge (
		.sysClk(sys_clk),
		.rst(rst),
		.resetPin_n(resetPin_n),
		.wdtOverflow(wdtOverflow),
		.pocLow(pocLow),
		.lviLow(lviLow),
		.srcLevel(srcLevel),
		.resetAny(resetAny),
		.resetNoLvi(resetNoLvi)
	);

	// per-source wake and service decision
	genvar gi;
	generate
		for (gi = 0; gi < NIRQ; gi++) begin : gIrq
			// a set mask flag keeps the source out of the wake logic
			assign unmasked[gi] = irqReq[gi] & ~interruptMaskFlag[gi];
			// high priority needs enable; low priority also needs in-service flag
			assign serviceable[gi] = unmasked[gi] & globalInterruptEnable &
				(~interruptPriorityFlag[gi] | inServicePriorityFlag);
		end
	endgenerate

	assign wakeAny = |unmasked;
	assign serveAny = |serviceable;

	// stabilisation length doubles with each select step
	assign stabCount = TCNT_W'(12'h001 << (STAB_BASE_SHIFT + int'(ctrlReg[CTRL_OSC_STAB_TIME_SELECT_LSB +: CTRL_OSC_STAB_TIME_SELECT_W])));

	assign inResetGrp = (state == SR_RESET) || (state == SR_RSTAB);
	assign running = (state == SR_RUN) || (state == SR_WSTAB) || (state == SR_WWAIT);

	// main sequencer; any reset source overrides every other state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= SR_RESET;
			stopHeld <= 1'b0;
			vecSel <= 1'b0;
			tif.load <= 1'b0;
			tif.count <= '0;
			oscStabDone <= 1'b0;
			stopRejected <= 1'b0;
			fetchResetVector <= 1'b0;
			clkSelHsReset <= 1'b0;
			resumeVectored <= 1'b0;
			resumeNext <= 1'b0;
		end else begin
			tif.load <= 1'b0;
			stopRejected <= 1'b0;
			fetchResetVector <= 1'b0;
			clkSelHsReset <= 1'b0;
			resumeVectored <= 1'b0;
			resumeNext <= 1'b0;
			if (resetAny) begin
				// reset ends stop but the stop picture is held meanwhile
				if (state == SR_STOP) begin
					stopHeld <= 1'b1;
				end
				state <= SR_RESET;
			end else begin
				case (state)
					SR_RESET: begin
						// release: wait for the internal fast oscillator to settle
						stopHeld <= 1'b0;
						oscStabDone <= 1'b0;
						tif.load <= 1'b1;
						tif.count <= stabCount;
						state <= SR_RSTAB;
					end
					SR_RSTAB: begin
						if (tif.done) begin
							oscStabDone <= 1'b1;
							state <= SR_RPROC;
						end
					end
					SR_RPROC: begin
						// every reset, whatever its source, fetches the same vector
						fetchResetVector <= 1'b1;
						clkSelHsReset <= 1'b1;
						state <= SR_RUN;
					end
					SR_RUN: begin
						if (stopExec) begin
							// stop only from the main system clock; else refused
							if (cpuOnMainClk) begin
								state <= SR_STOP;
							end else begin
								stopRejected <= 1'b1;
							end
						end
					end
					SR_STOP: begin
						if (wakeAny) begin
							vecSel <= serveAny;
							tif.load <= 1'b1;
							if (cpuOnExtClk) begin
								// no oscillator to settle on an external clock
								tif.count <= serveAny ? WAIT_VEC_CLKS : WAIT_NEXT_CLKS;
								state <= SR_WWAIT;
							end else begin
								oscStabDone <= 1'b0;
								tif.count <= stabCount;
								state <= SR_WSTAB;
							end
						end
					end
					SR_WSTAB: begin
						if (tif.done) begin
							oscStabDone <= 1'b1;
							tif.load <= 1'b1;
							tif.count <= vecSel ? WAIT_VEC_CLKS : WAIT_NEXT_CLKS;
							state <= SR_WWAIT;
						end
					end
					SR_WWAIT: begin
						// wait over: vector into the handler or carry on
						if (tif.done) begin
							resumeVectored <= vecSel;
							resumeNext <= ~vecSel;
							state <= SR_RUN;
						end
					end
					default: begin
						state <= SR_RESET;
					end
				endcase
			end
		end
	end

	// cpu, pin and oscillator controls, one flop each, sixteen for the reset vector address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpuClockRun <= 1'b0;
			cpuReset <= 1'b1;
			pinsHighZ <= 1'b1;
			crystalOscRun <= 1'b0;
			hsOscRun <= 1'b0;
			lsOscRun <= 1'b0;
			extClkAccept <= 1'b0;
			stopActive <= 1'b0;
			lviLogicReset <= 1'b1;
			resetVectorAddr <= RESET_VEC_ADDR;
		end else begin
			cpuClockRun <= state == SR_RUN;
			cpuReset <= inResetGrp || (state == SR_RPROC);
			// pins float through reset and the settle that follows
			pinsHighZ <= inResetGrp;
			// crystal and fast oscillators stopped in reset and in stop
			crystalOscRun <= xtalEnable & running;
			hsOscRun <= (state == SR_RSTAB) || (state == SR_RPROC) || (running && !hsOscStopBit);
			// slow oscillator ignores stop, so the watchdog keeps counting
			lsOscRun <= ~inResetGrp & ~ctrlReg[CTRL_LSSTOP_BIT];
			extClkAccept <= running;
			stopActive <= (state == SR_STOP) || (state == SR_RESET && stopHeld);
			lviLogicReset <= resetNoLvi;
			resetVectorAddr <= RESET_VEC_ADDR;
		end
	end

	// peripheral run enables; while stopped only self-clocked sources run
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			uartRun <= 1'b0;
			csiRun <= 1'b0;
			iicRun <= 1'b0;
		end else if (inResetGrp) begin
			uartRun <= 1'b0;
			csiRun <= 1'b0;
			iicRun <= 1'b0;
		end else if (state == SR_STOP) begin
			uartRun <= uartClkFromTimer8a;
			csiRun <= csiExtClk;
			iicRun <= iicExtSerialClockPin;
		end else begin
			uartRun <= 1'b1;
			csiRun <= 1'b1;
			iicRun <= 1'b1;
		end
	end

	// control register; only the block reset returns it to CTRL_RESET
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlReg <= CTRL_RESET;
		end else if (regWr && regAddr == REG_CTRL) begin
			ctrlReg <= {4'h0, regWdata[3:0]};
		end
	end

	// sticky causes, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			causeFlags <= '0;
		end else begin
			if (regWr && regAddr == REG_CAUSE) begin
				causeFlags <= (causeFlags & ~regWdata[CAUSE_W-1:0]) | {stopRejected, srcLevel};
			end else begin
				causeFlags <= causeFlags | {stopRejected, srcLevel};
			end
		end
	end

	// read data stands the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			regRdata <= '0;
		end else if (regRd) begin
			case (regAddr)
				REG_CTRL: regRdata <= ctrlReg;
				// stabilisation status lets software pick its moment to switch back
				REG_STATUS: regRdata <= {3'h0, oscStabDone, stopHeld, 3'(state)};
				REG_CAUSE: regRdata <= {3'h0, causeFlags};
				default: regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end
endmodule

// *** design/srpc_pkg.sv ***
// constants and types shared by the stop-release and reset sequencer
package srpc_pkg;
	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_CAUSE = 4'h2;
	// control register fields and reset value
	localparam int CTRL_OSC_STAB_TIME_SELECT_LSB = 0;
	localparam int CTRL_OSC_STAB_TIME_SELECT_W = 3;
	localparam int CTRL_LSSTOP_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h05;
	// cause register fields
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_WDT = 1;
	localparam int CAUSE_POC = 2;
	localparam int CAUSE_LVI = 3;
	localparam int CAUSE_STOPREJ = 4;
	localparam int CAUSE_W = 5;
	// number of interrupt sources watched while stopped
	localparam int NIRQ = 4;
	// timer width and counts in sys_clk cycles
	localparam int TCNT_W = 12;
	localparam int STAB_BASE_SHIFT = 4;
	localparam logic [TCNT_W-1:0] WAIT_VEC_CLKS = 12'h011;
	localparam logic [TCNT_W-1:0] WAIT_NEXT_CLKS = 12'h00B;
	localparam logic [7:0] WDT_HOLD_CLKS = 8'h10;
	// reset vector location
	localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
	// sequencer states
	typedef enum logic [2:0] {
		SR_RUN, SR_STOP, SR_WSTAB, SR_WWAIT, SR_RESET, SR_RSTAB, SR_RPROC
	} srpc_state_t;
endpackage

// *** design/srpc_timer_if.sv ***
// carrier between the sequencer and its wait timer
`timescale 1ns/1ps
interface srpc_timer_if;
	import srpc_pkg::*;
	logic load; // start a new count
	logic [TCNT_W-1:0] count; // cycles to wait
	logic busy; // counting
	logic done; // one-cycle pulse when the count elapses
	modport master (output load, output count, input busy, input done);
	modport timer (input load, input count, output busy, output done);
endinterface

// *** design/srpc_wait_timer.sv ***
// down counter for stabilisation and wake-up waits
`timescale 1ns/1ps
module srpc_wait_timer (
	// clock and reset
	input wire logic sysClk,
	input wire logic rst,
	// control from the sequencer
	srpc_timer_if.timer tif
);
	import srpc_pkg::*;

	logic [TCNT_W-1:0] cnt; // remaining cycles

	// load restarts the count; done fires when the last cycle passes
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			tif.busy <= 1'b0;
			tif.done <= 1'b0;
		end else begin
			tif.done <= 1'b0;
			if (tif.load) begin
				cnt <= tif.count;
				tif.busy <= 1'b1;
			end else if (tif.busy) begin
				if (cnt <= 12'h001) begin
					tif.busy <= 1'b0;
					tif.done <= 1'b1;
				end else begin
					cnt <= cnt - 12'h001;
				end
			end
		end
	end
endmodule

// *** design/srpc_reset_merge.sv ***
// merges the four reset sources into registered levels
`timescale 1ns/1ps
module srpc_reset_merge (
	// clock and reset
	input wire logic sysClk,
	input wire logic rst,
	// reset sources
	input wire logic resetPin_n,
	input wire logic wdtOverflow,
	input wire logic pocLow,
	input wire logic lviLow,
	// merged results
	output logic [3:0] srcLevel,
	output logic resetAny,
	output logic resetNoLvi
);
	import srpc_pkg::*;

	logic pinMeta; // first synchroniser stage, read only by pinSync
	logic pinSync; // pin level in the clock domain
	logic [7:0] wdtHold; // stretch of the watchdog pulse

	// two-flop synchroniser so the pin release never lands mid-edge
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
		end else begin
			pinMeta <= resetPin_n;
			pinSync <= pinMeta;
		end
	end

	// watchdog reset holds a fixed time and then lets go by itself
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			wdtHold <= '0;
		end else if (wdtOverflow) begin
			wdtHold <= WDT_HOLD_CLKS;
		end else if (wdtHold != 8'h00) begin
			wdtHold <= wdtHold - 8'h01;
		end
	end

	// any source pulls the internal reset; detectors release on their own
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			srcLevel <= '0;
			resetAny <= 1'b1;
			resetNoLvi <= 1'b1;
		end else begin
			srcLevel[CAUSE_PIN] <= ~pinSync;
			srcLevel[CAUSE_WDT] <= wdtHold != 8'h00;
			srcLevel[CAUSE_POC] <= pocLow;
			srcLevel[CAUSE_LVI] <= lviLow;
			resetAny <= ~pinSync | (wdtHold != 8'h00) | pocLow | lviLow;
			// the voltage detector is never reset by its own alarm
			resetNoLvi <= ~pinSync | (wdtHold != 8'h00) | pocLow;
		end
	end
endmodule

// *** sim/srpc_stop_reset_ctrl_properties.sv ***
// assertions on the ports of the stop-release and reset sequencer
`timescale 1ns/1ps
module srpc_stop_reset_ctrl_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// watched inputs
	input wire logic resetPin_n, wdtOverflow, pocLow, lviLow, stopExec, cpuOnMainClk, cpuOnExtClk,
	input wire logic [srpc_pkg::NIRQ-1:0] irqReq, interruptMaskFlag, interruptPriorityFlag,
	input wire logic globalInterruptEnable,
	// watched outputs
	input wire logic cpuClockRun, cpuReset, fetchResetVector, clkSelHsReset, resumeVectored, resumeNext,
	input wire logic [15:0] resetVectorAddr,
	input wire logic stopActive, pinsHighZ, crystalOscRun, hsOscRun, lsOscRun, extClkAccept, lviLogicReset
);
	import srpc_pkg::*;
	logic [NIRQ-1:0] live; // requests not masked
	logic [4:0] quietCnt; // cycles free of any foreign reset
	assign live = irqReq & ~interruptMaskFlag;
	// saturating count, cleared by any reset the detector did not cause
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			quietCnt <= 5'h00;
		end else if (!resetPin_n || pocLow || wdtOverflow || (cpuReset && !lviLow)) begin
			quietCnt <= 5'h00;
		end else if (quietCnt != 5'h1F) begin
			quietCnt <= quietCnt + 5'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_pins_float_reset: assert property (pinsHighZ |-> cpuReset)
		else $error("pins float outside reset");
	a_vector_fetch: assert property (fetchResetVector |-> clkSelHsReset && resetVectorAddr == 16'h0000)
		else $error("bad reset vector fetch");
	a_fetch_from_reset: assert property (fetchResetVector |-> $past(cpuReset))
		else $error("vector fetch without reset");
	a_osc_stop_reset: assert property (pocLow [*5] |-> !crystalOscRun && !hsOscRun && !lsOscRun && !extClkAccept)
		else $error("oscillator live in reset");
	a_pin_reset: assert property (!resetPin_n [*6] |-> cpuReset && pinsHighZ)
		else $error("pin low without reset");
	a_lvi_spared: assert property (lviLow && quietCnt > 5'h17 |-> !lviLogicReset)
		else $error("detector logic reset by itself");
	a_masked_hold: assert property ((stopActive && !cpuReset && live == '0 && resetPin_n && !pocLow && !lviLow
		&& !wdtOverflow) [*3] |=> stopActive)
		else $error("stop left without cause");
	a_wake_vec_time: assert property ($fell(stopActive) && !cpuReset && cpuOnExtClk && globalInterruptEnable
		&& (live & ~interruptPriorityFlag) != '0 |-> ##[15:19] resumeVectored)
		else $error("vectored wake late");
	a_wake_next_time: assert property ($fell(stopActive) && !cpuReset && cpuOnExtClk && !globalInterruptEnable
		|-> ##[9:13] resumeNext)
		else $error("plain wake late");
	a_stop_refused: assert property (stopExec && cpuClockRun && !cpuOnMainClk |-> ##2 !stopActive)
		else $error("stop taken off main clock");
endmodule
bind srpc_stop_reset_ctrl srpc_stop_reset_ctrl_properties u_props (.sys_clk, .rst, .resetPin_n, .wdtOverflow,
	.pocLow, .lviLow, .stopExec, .cpuOnMainClk, .cpuOnExtClk, .irqReq, .interruptMaskFlag, .interruptPriorityFlag,
	.globalInterruptEnable, .cpuClockRun, .cpuReset, .fetchResetVector, .clkSelHsReset, .resumeVectored,
	.resumeNext, .resetVectorAddr, .stopActive, .pinsHighZ, .crystalOscRun, .hsOscRun, .lsOscRun, .extClkAccept,
	.lviLogicReset);

// *** sim/srpc_far_model.sv ***
// far-side reset source driving the external reset pin
`timescale 1ns/1ps
module srpc_far_model #(
	parameter int LOW_CLKS = 250 // ten microseconds at 40 ns
) (
	// clock
	input wire logic sys_clk,
	// request for one pin reset
	input wire logic pinPulse,
	// external reset pin
	output logic resetPin_n
);
	int lowLeft = 0; // cycles left low
	initial resetPin_n = 1'b1;
	// a shorter pulse would not be a valid reset, so the full minimum is always kept
	always @(posedge sys_clk) begin
		if (pinPulse) begin
			lowLeft <= LOW_CLKS;
			resetPin_n <= 1'b0;
		end else if (lowLeft > 1) begin
			lowLeft <= lowLeft - 1;
		end else begin
			resetPin_n <= 1'b1;
		end
	end
endmodule

// *** sim/test_stop_release_reset_control.sv ***
// self-checking bench for the stop-release and reset sequencer
`timescale 1ns/1ps
module test_stop_release_reset_control;
	import srpc_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, pinPulse = 1'b0, resetPin_n;
	logic wdtOverflow = 1'b0, pocLow = 1'b0, lviLow = 1'b0, stopExec = 1'b0;
	logic cpuOnMainClk = 1'b1, cpuOnExtClk = 1'b1, xtalEnable = 1'b1, hsOscStopBit = 1'b0;
	logic [NIRQ-1:0] irqReq = '0, interruptMaskFlag = '1, interruptPriorityFlag = '0;
	logic globalInterruptEnable = 1'b0, inServicePriorityFlag = 1'b0;
	logic uartClkFromTimer8a = 1'b0, csiExtClk = 1'b0, iicExtSerialClockPin = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata, rd;
	logic cpuClockRun, cpuReset, fetchResetVector, clkSelHsReset, resumeVectored, resumeNext, stopActive;
	logic [15:0] resetVectorAddr;
	logic pinsHighZ, crystalOscRun, hsOscRun, lsOscRun, extClkAccept, uartRun, csiRun, iicRun, lviLogicReset;
	int nErrors = 0, cmpCount = 0;
	srpc_stop_reset_ctrl u_dut (.sys_clk, .rst, .resetPin_n, .wdtOverflow, .pocLow, .lviLow, .stopExec,
		.cpuOnMainClk, .cpuOnExtClk, .xtalEnable, .hsOscStopBit, .irqReq, .interruptMaskFlag,
		.interruptPriorityFlag, .globalInterruptEnable, .inServicePriorityFlag, .uartClkFromTimer8a, .csiExtClk,
		.iicExtSerialClockPin, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cpuClockRun, .cpuReset,
		.fetchResetVector, .resetVectorAddr, .clkSelHsReset, .resumeVectored, .resumeNext, .stopActive,
		.pinsHighZ, .crystalOscRun, .hsOscRun, .lsOscRun, .extClkAccept, .uartRun, .csiRun, .iicRun,
		.lviLogicReset);
	srpc_far_model u_far (.sys_clk, .pinPulse, .resetPin_n);
	// free-running 25 MHz clock
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [3:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask
	task automatic checkCause(input int b);
		regRead(REG_CAUSE);
		cmp(rd, 8'h01 << b);
		regWrite(REG_CAUSE, 8'hFF);
		regRead(REG_CAUSE);
		cmp(rd, 8'h00);
	endtask
	task automatic waitFetch;
		int n;
		for (n = 0; fetchResetVector !== 1'b1; n++) begin
			tick(1);
			if (n > 3000) begin
				nErrors++;
				conclude();
			end
		end
		cmp(resetVectorAddr, 16'h0000);
		cmp(clkSelHsReset, 16'h0001);
	endtask
	task automatic waitResume(output int n);
		for (n = 0; resumeVectored !== 1'b1 && resumeNext !== 1'b1; n++) begin
			tick(1);
			if (n > 3000) begin
				nErrors++;
				conclude();
			end
		end
	endtask
	task automatic stopGo;
		@(posedge sys_clk);
		stopExec <= 1'b1;
		@(posedge sys_clk);
		stopExec <= 1'b0;
		tick(4);
	endtask
	task automatic testPowerUp;
		#1 cmp({cpuReset, pinsHighZ}, 2'h3);
		waitFetch();
		regRead(REG_CTRL);
		cmp(rd, CTRL_RESET);
		regRead(4'hF);
		cmp(rd, 8'h00);
		// shortest stabilisation keeps later resets quick
		regWrite(REG_CTRL, 8'h00);
		regRead(REG_CTRL);
		cmp(rd, 8'h00);
		regWrite(REG_CAUSE, 8'hFF);
		$display("test power up finished");
	endtask
	task automatic testWakeVectored;
		int n;
		@(posedge sys_clk);
		uartClkFromTimer8a <= 1'b1;
		iicExtSerialClockPin <= 1'b1;
		globalInterruptEnable <= 1'b1;
		interruptMaskFlag <= 4'hE;
		stopGo();
		cmp(stopActive, 16'h0001);
		cmp({uartRun, csiRun, iicRun}, 16'h0005);
		cmp(lsOscRun, 16'h0001);
		@(posedge sys_clk);
		irqReq <= 4'h1;
		waitResume(n);
		cmp(resumeVectored, 16'h0001);
		cmp(n >= 17 && n <= 20, 16'h0001);
		@(posedge sys_clk);
		irqReq <= 4'h0;
		$display("test vectored wake finished");
	endtask
	task automatic testWakeNext(input logic ext, input logic ie, input int lo, input int hi);
		int n;
		@(posedge sys_clk);
		cpuOnExtClk <= ext;
		globalInterruptEnable <= ie;
		interruptPriorityFlag <= 4'hF;
		interruptMaskFlag <= 4'hF;
		stopGo();
		@(posedge sys_clk);
		irqReq <= 4'h2;
		tick(40);
		cmp({stopActive, cpuClockRun, resumeNext}, 16'h0004);
		@(posedge sys_clk);
		interruptMaskFlag <= 4'hD;
		waitResume(n);
		cmp(resumeNext, 16'h0001);
		cmp(n >= lo && n <= hi, 16'h0001);
		// back in run with the stabilisation count shown as elapsed
		regRead(REG_STATUS);
		cmp(rd, 8'h10);
		@(posedge sys_clk);
		irqReq <= 4'h0;
		$display("test plain wake finished");
	endtask
	task automatic testRefused;
		@(posedge sys_clk);
		cpuOnMainClk <= 1'b0;
		stopGo();
		cmp({stopActive, cpuClockRun}, 16'h0001);
		checkCause(CAUSE_STOPREJ);
		@(posedge sys_clk);
		cpuOnMainClk <= 1'b1;
		$display("test refused stop finished");
	endtask
	task automatic testWdtInStop;
		stopGo();
		@(posedge sys_clk);
		wdtOverflow <= 1'b1;
		@(posedge sys_clk);
		wdtOverflow <= 1'b0;
		tick(8);
		cmp({stopActive, pinsHighZ, cpuReset, lviLogicReset}, 16'h000F);
		waitFetch();
		checkCause(CAUSE_WDT);
		$display("test watchdog in stop finished");
	endtask
	task automatic testDetector(input logic isLvi);
		tick(30);
		@(posedge sys_clk);
		pocLow <= !isLvi;
		lviLow <= isLvi;
		tick(30);
		cmp({cpuReset, hsOscRun, crystalOscRun, lsOscRun, extClkAccept, lviLogicReset}, {5'h10, !isLvi});
		@(posedge sys_clk);
		pocLow <= 1'b0;
		lviLow <= 1'b0;
		waitFetch();
		checkCause(isLvi ? CAUSE_LVI : CAUSE_POC);
		$display("test detector reset finished");
	endtask
	task automatic testPinReset;
		@(posedge sys_clk);
		pinPulse <= 1'b1;
		@(posedge sys_clk);
		pinPulse <= 1'b0;
		tick(200);
		cmp({cpuReset, pinsHighZ, extClkAccept}, 16'h0006);
		waitFetch();
		checkCause(CAUSE_PIN);
		$display("test pin reset finished");
	endtask
	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		testPowerUp();
		testWakeVectored();
		testWakeNext(1'b1, 1'b0, 11, 14);
		// fast oscillator left running and cpu off the external clock before stop
		testWakeNext(1'b0, 1'b1, 27, 32);
		testRefused();
		testWdtInStop();
		testDetector(1'b1);
		testDetector(1'b0);
		testPinReset();
		conclude();
	end
endmodule
